// [core/pbl_limit_cfg.sv]
// APB register bank and per-channel rate policer for port bandwidth limiting
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module pbl_limit_cfg #(
	parameter int TICK_CYC = pbl_pkg::REFILL_CYC,
	parameter logic [pbl_pkg::CREDIT_W-1:0] BURST = pbl_pkg::BURST_BITS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pbl_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pbl_pkg::pbl_frame_req_s frame_req [pbl_pkg::NUM_CH],
	output pbl_pkg::pbl_frame_res_s frame_res [pbl_pkg::NUM_CH],
	output logic [pbl_pkg::NUM_CH-1:0] limit_on,
	output logic [pbl_pkg::KBPS_W-1:0] limit_kbps [pbl_pkg::NUM_CH],
	output logic port4_pcs_clock_invert,
	output logic carrier_length_check_en,
	output logic new_rate_scheme_enable
);
	import pbl_pkg::*;

	logic [REG_W-1:0] regs [NUM_REGS];
	logic [7:0] idx;
	logic hit;
	logic [2:0] slot;
	logic [REG_W-1:0] rd_val;
	logic [3*REG_W-1:0] low_nib;
	logic [3*REG_W-1:0] up_nib;
	logic access_done;
	logic [16:0] tick_cnt;
	logic tick;

	// address decode: word aligned, index in the mapped window
	always_comb begin
		idx = paddr[9:2];
		hit = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0)
			&& (idx >= IDX_RX_THR_LOW) && (idx <= IDX_TX_THR_UPPER);
		slot = 3'(idx - IDX_RX_THR_LOW);
		rd_val = hit ? regs[slot] : REG_RESET;
	end

	assign access_done = psel && penable && pready;

	// one wait state in the access phase, then the answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready) begin
			prdata <= {16'h0000, pwrite ? 16'h0000 : rd_val};
			pslverr <= !hit;
		end else begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
	end

	// plain storage, every bit writable including the reserved one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				regs[i] <= REG_RESET;
			end
		end else if (access_done && pwrite && hit) begin
			if (pstrb[0]) begin
				regs[slot][7:0] <= pwdata[7:0];
			end
			if (pstrb[1]) begin
				regs[slot][15:8] <= pwdata[15:8];
			end
		end
	end

	// nibble n of the low and upper vectors belongs to channel n
	always_comb begin
		low_nib = {regs[SLOT_TX_LOW], regs[SLOT_MIXED_LOW], regs[SLOT_RX_LOW]};
		up_nib = {regs[SLOT_TX_UP], regs[SLOT_MIXED_UP], regs[SLOT_RX_UP]};
	end

	// control bits, registered so every output leaves a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port4_pcs_clock_invert <= 1'b0;
			carrier_length_check_en <= 1'b1;
			new_rate_scheme_enable <= 1'b0;
		end else begin
			port4_pcs_clock_invert <= regs[SLOT_ENABLE][BIT_PCS_CLOCK_INVERT];
			// inverted sense: a zero keeps the check running
			carrier_length_check_en <= !regs[SLOT_ENABLE][BIT_CARRIER_CHECK_DISABLE];
			new_rate_scheme_enable <= regs[SLOT_ENABLE][BIT_NEW_RATE_SCHEME];
		end
	end

	// refill tick once per refill period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt <= 17'h00000;
			tick <= 1'b0;
		end else if (tick_cnt >= 17'(TICK_CYC - 1)) begin
			tick_cnt <= 17'h00000;
			tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 17'h00001;
			tick <= 1'b0;
		end
	end

	// one token bucket per port and direction, counted in bits
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			logic [THR_W-1:0] thr;
			logic [KBPS_W-1:0] kbps;
			logic en;
			logic [CREDIT_W-1:0] credit;
			logic [CREDIT_W-1:0] next_credit;
			logic [CREDIT_W-1:0] refill;
			logic [CREDIT_W-1:0] need;
			logic ok;

			always_comb begin
				thr = {up_nib[4*ch +: 4], low_nib[4*ch +: 4]};
				kbps = {thr, KBPS_PAD};
				en = regs[SLOT_ENABLE][CH_EN_BIT[ch]];
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					limit_kbps[ch] <= '0;
					limit_on[ch] <= 1'b0;
				end else begin
					limit_kbps[ch] <= kbps;
					limit_on[ch] <= en;
				end
			end

			// one kbit/s over one millisecond is exactly one bit of credit
			always_comb begin
				refill = credit;
				if (tick) begin
					refill = credit + CREDIT_W'(limit_kbps[ch]);
					if (refill > BURST || refill < credit) begin
						refill = BURST;
					end
				end
				need = CREDIT_W'({frame_req[ch].len, 3'h0});
				ok = !limit_on[ch] || (refill >= need);
				next_credit = refill;
				if (!limit_on[ch]) begin
					// a freshly enabled limiter starts with a full bucket
					next_credit = BURST;
				end else if (frame_req[ch].valid && ok) begin
					next_credit = refill - need;
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					credit <= '0;
					frame_res[ch] <= '0;
				end else begin
					credit <= next_credit;
					frame_res[ch].valid <= frame_req[ch].valid;
					frame_res[ch].pass <= frame_req[ch].valid && ok;
				end
			end
		end
	endgenerate
endmodule : pbl_limit_cfg

// [core/pbl_pkg.sv]
// constants, types and register map of the port bandwidth limit block
// What this block does
// - limit in kbit/s is the eight threshold bits followed by six zero bits
// - receive limiting on ports 0..5 follows enable bits 0,2,4,6,7,8
// - transmit limiting on ports 0..5 follows enable bits 1,3,5,9,10,11
// - first basic register holds rx ports 3..0, bit 3 over bits 2..0
// - second basic register: tx ports 1,0 high byte, rx ports 5,4 low byte
// - enable bit 15 set inverts the port 4 coding sublayer clock
// - enable bit 14 clear checks carrier sense length, set disables it
// - enable bit 12 set selects the newer rate control scheme
// - all bits read and write, bit 13 too, every register resets to zero
// - threshold bits 7..4 sit in extended registers as nibbles
package pbl_pkg;
	localparam int NUM_PORTS = 6;
	localparam int NUM_CH = 12;
	localparam int NUM_REGS = 7;
	localparam int REG_W = 16;
	localparam int THR_W = 8;
	localparam int KBPS_W = 14;
	localparam int LEN_W = 11;
	localparam int CREDIT_W = 24;
	localparam int ADDR_W = 12;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_RX_THR_LOW = 8'h31;
	localparam logic [7:0] IDX_MIXED_THR_LOW = 8'h32;
	localparam logic [7:0] IDX_LIMIT_ENABLE = 8'h33;
	localparam logic [7:0] IDX_TX_THR_LOW_HI_PORTS = 8'h34;
	localparam logic [7:0] IDX_RX_THR_UPPER = 8'h35;
	localparam logic [7:0] IDX_MIXED_THR_UPPER = 8'h36;
	localparam logic [7:0] IDX_TX_THR_UPPER = 8'h37;
	localparam logic [15:0] REG_RESET = 16'h0000;

	// storage slots, in register index order
	localparam int SLOT_RX_LOW = 0;
	localparam int SLOT_MIXED_LOW = 1;
	localparam int SLOT_ENABLE = 2;
	localparam int SLOT_TX_LOW = 3;
	localparam int SLOT_RX_UP = 4;
	localparam int SLOT_MIXED_UP = 5;
	localparam int SLOT_TX_UP = 6;

	// enable register fields
	localparam int BIT_PCS_CLOCK_INVERT = 15;
	localparam int BIT_CARRIER_CHECK_DISABLE = 14;
	localparam int BIT_NEW_RATE_SCHEME = 12;
	// channels 0..5 receive ports 0..5, channels 6..11 transmit ports 0..5
	localparam int CH_EN_BIT [NUM_CH] = '{0, 2, 4, 6, 7, 8, 1, 3, 5, 9, 10, 11};
	localparam logic [5:0] KBPS_PAD = 6'h00;

	// credit refill period
	localparam int CLK_NS = 8;
	localparam int REFILL_NS = 1000000;
	localparam int REFILL_CYC = REFILL_NS / CLK_NS;
	localparam logic [CREDIT_W-1:0] BURST_BITS = 24'h0186A0;

	typedef struct packed {
		logic valid;
		logic [LEN_W-1:0] len;
	} pbl_frame_req_s;

	typedef struct packed {
		logic valid;
		logic pass;
	} pbl_frame_res_s;
endpackage : pbl_pkg

// [testbench/pbl_limit_cfg_asserts.sv]
// port assertions for the bandwidth limit block
`timescale 1ns/1ps
module pbl_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [11:0] limit_on,
	input wire logic port4_pcs_clock_invert,
	input wire logic carrier_length_check_en,
	input wire logic new_rate_scheme_enable
);
	import pbl_pkg::*;
	wire logic we = pready && psel && pwrite && !pslverr && paddr == 12'h0CC && pstrb[1:0] == 2'h3;
	logic [15:0] w2;
	// write data lined up with the edge where its outputs land
	always_ff @(posedge pclk) w2 <= $past(pwdata[15:0]);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	rdy_late_a: assert property (psel && $rose(penable) |=> pready) else $error("late");
	rdy_once_a: assert property (pready |=> !pready) else $error("long");
	err_data_a: assert property (pready && pslverr |-> prdata == '0) else $error("data");
	rst_val_a: assert property ($rose(presetn) |-> limit_on == '0) else $error("rst");
	en_map_a: assert property (we |-> ##2 limit_on ==
		{w2[11:9], w2[5], w2[3], w2[1], w2[8:6], w2[4], w2[2], w2[0]}) else $error("map");
	clk_inv_a: assert property (we |-> ##2 port4_pcs_clock_invert == w2[15])
		else $error("inv");
	len_chk_a: assert property (we |-> ##2 carrier_length_check_en == !w2[14])
		else $error("len");
	new_sch_a: assert property (we |-> ##2 new_rate_scheme_enable == w2[12])
		else $error("new");
	cover property (we);
	cover property (pready && pslverr);
	cover property ($rose(presetn));
endmodule : pbl_chk
bind pbl_limit_cfg pbl_chk chk_i (.*);

// [testbench/testbench.sv]
// self-checking bench for the bandwidth limit block
`timescale 1ns/1ps
module testbench;
	import pbl_pkg::*;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h000, ra;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, port4_pcs_clock_invert;
	logic carrier_length_check_en, new_rate_scheme_enable;
	pbl_frame_req_s frame_req [NUM_CH] = '{default: '0};
	pbl_frame_res_s frame_res [NUM_CH];
	logic [NUM_CH-1:0] limit_on;
	logic [KBPS_W-1:0] limit_kbps [NUM_CH];
	logic [47:0] lo, up;
	// rx port 0 keeps a zero limit, so its bucket never refills
	logic [15:0] rx [7] = '{16'h1230, 16'h5678, 16'hF0F1, 16'hCDEF, 16'h9AB0, 16'h2468, 16'h1357};
	int errors = 0, check_count = 0;
	always #4 pclk = ~pclk;
	pbl_limit_cfg #(.TICK_CYC(50), .BURST(24'h000400)) uut (.*, .pstrb(4'hF));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		errors += int'(s !== e);
		if (s !== e) $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
	endtask : chk
	task automatic complete_run;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : complete_run
	task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
		int n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'hFFFF, d};
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1 && ++n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
		chk(32'(n >= 20), 32'h0);
		if (n >= 20) complete_run();
	endtask : apb
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		for (int i = 0; i < 7; i++) begin
			ra = 12'(4 * (IDX_RX_THR_LOW + i));
			apb(1'h0, ra, 16'h0);
			chk(rd, 32'h0);
			apb(1'h1, ra, rx[i]);
			apb(1'h0, ra, 16'h0);
			chk(rd, {16'h0, rx[i]});
		end
		lo = {rx[3], rx[1], rx[0]};
		up = {rx[6], rx[5], rx[4]};
		for (int c = 0; c < NUM_CH; c++)
			chk(limit_kbps[c], {up[c*4+:4], lo[c*4+:4], 6'h00});
		apb(1'h0, 12'h0E0, 16'h0);
		chk(rd, 32'h0);
		chk(er, 32'h1);
		$display("test rows done");
		frame_req[0] <= '{1'h1, 11'h040};
		frame_req[6] <= '{1'h1, 11'h040};
		// third offer outruns the full bucket; look while its answer stands
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		chk(frame_res[0], 32'h2);
		chk(frame_res[6], 32'h3);
		@(posedge pclk);
		frame_req[0] <= '0;
		frame_req[6] <= '0;
		@(posedge pclk);
		$display("test policing done");
		presetn <= 1'h0;
		@(posedge pclk);
		chk(limit_on, 32'h0);
		chk(carrier_length_check_en, 32'h1);
		presetn <= 1'h1;
		@(posedge pclk);
		$display("test reset done");
		complete_run();
	end
endmodule : testbench
